// ### shared/hbs_pkg.sv
package hbs_pkg;

    // register port geometry, master and bank counts
    localparam int ADDR_W      = 8;
    localparam int DATA_W      = 32;
    localparam int NUM_MASTERS = 5;
    localparam int NUM_BANKS   = 6;

    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] OFS_CFG_ADDR = 8'h00;
    localparam logic [7:0] OFS_CFG_DATA = 8'h04;
    localparam logic [7:0] OFS_PM_CTRL  = 8'h08;
    localparam logic [7:0] OFS_MEM_CTRL = 8'h0c;
    localparam logic [7:0] OFS_SMM_CTRL = 8'h10;
    localparam logic [7:0] OFS_STRAPS   = 8'h14;
    localparam logic [7:0] OFS_STATUS   = 8'h18;

    // field positions
    localparam int PM_GCLK_EN   = 0;
    localparam int PM_CLKRUN_EN = 1;
    localparam int PM_ARB_EN    = 2;
    localparam int MEM_TECH_BIT = 8;
    localparam int SMM_EXT_BIT  = 0;
    localparam int SMM_SIZE_LSB = 1;
    localparam int CFG_EN_BIT   = 31;

    // strap levels: an unstrapped pin reads low, a pull-up reads high
    localparam logic STRAP_OPEN = 1'h0;

    // in-order queue depths
    localparam logic [3:0] IOQ_DEPTH_MAX = 4'h8;
    localparam logic [3:0] IOQ_DEPTH_MIN = 4'h1;

    // arbiter and clock-run counts
    localparam logic [2:0] OWNER_NONE  = 3'h7;
    localparam logic [3:0] IDLE_CYCLES = 4'h8;
    localparam logic [3:0] CR_WAIT     = 4'h4;

    // values after reset
    localparam logic [2:0] PM_RESET = 3'h4;

    typedef enum logic [1:0] {
        CR_RUN     = 2'b00,
        CR_RELEASE = 2'b01,
        CR_STOPPED = 2'b10
    } hbs_clkrun_type;

    // strap pins sampled from the memory address bus
    typedef struct packed {
        logic hostFreq;
        logic queueDepth;
        logic quickStart;
        logic agpDisable;
        logic moduleConfig;
        logic hostBufferMode;
    } hbs_strap_type;

    // configuration decoded from the straps
    typedef struct packed {
        logic       host100;
        logic [3:0] ioqDepth;
        logic       quickStartMode;
        logic       agpEnable;
        logic       extModule;
        logic       mobileBuffers;
    } hbs_boot_type;

    // one configuration cycle towards the pci side
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        internal;
        logic [31:0] ad;
        logic [31:0] data;
    } hbs_cfg_cycle_type;

    typedef struct packed {
        logic              strapDone;
        hbs_boot_type      boot;
        logic [31:0]       cfgAddr;
        logic [31:0]       cfgRdData;
        logic [2:0]        pmCtrl;
        logic [5:0]        bankEn;
        logic              sdramTech;
        logic              smmExt;
        logic [1:0]        smmSize;
        logic [31:0]       rdData;
        hbs_cfg_cycle_type cfg;
        logic [4:0]        gntN;
        logic [2:0]        owner;
        logic [2:0]        lastOwner;
        hbs_clkrun_type    crState;
        logic [3:0]        crCnt;
        logic              clkrunOeN;
        logic              pciClkOn;
        logic              coreClkGate;
    } hbs_state_type;

    localparam hbs_state_type STATE_RESET = '{
        gntN      : 5'h1f,
        owner     : OWNER_NONE,
        lastOwner : 3'h4,
        crState   : CR_RUN,
        pciClkOn  : 1'h1,
        pmCtrl    : PM_RESET,
        default   : '0
    };

endpackage

// ### src/hbs_bridge_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RQ1 - post-reset configuration comes from strap levels on the memory address bus
// RQ2 - open host frequency strap gives 66 MHz host bus operation
// RQ3 - open queue depth strap gives the maximum depth of eight
// RQ4 - quick start strap held high selects quick start clock control
// RQ5 - agp enabled by default; board pull-up on its strap disables agp
// RQ6 - open module configuration strap selects standard module mode
// RQ7 - buffer mode strap held high selects mobile host bus buffers
// RQ8 - arbitrate up to five pci masters, one request/grant pair each
// RQ9 - support clock-run; a device asserts the open-drain line to run clock
// RQ10 - configuration cycles only through access mechanism one
// RQ11 - bridge is device zero; address line 11 never used as select
// RQ12 - address line 12 selects agp; others use line 13 or higher
// RQ13 - board designer should give the south bridge address line 18
// RQ14 - one memory control set, six sdram banks, one clock enable each
// RQ15 - standard mode: no eight banks, second address bus or 100 MHz
// RQ16 - all dram rows share one technology, edo or sdram
// RQ17 - gate internal clock when enabled and processor and pci are idle
// RQ18 - compatible and extended smm memory; extended up to one megabyte
// RQ19 - agp side clocked asynchronously to the core
// RQ20 - straps latched at reset release and held until next reset
module hbs_bridge_ctrl #(
    parameter int NUM_MASTERS = hbs_pkg::NUM_MASTERS,
    parameter int NUM_BANKS   = hbs_pkg::NUM_BANKS
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // register port
    input  wire logic [hbs_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [31:0]               regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic [31:0]                    regRdata,
    // strap pins
    input  wire hbs_pkg::hbs_strap_type    strapPins,
    output hbs_pkg::hbs_boot_type          bootCfg,
    // pci arbitration
    input  wire logic [NUM_MASTERS-1:0]    reqN,
    output logic [NUM_MASTERS-1:0]         gntN,
    input  wire logic                      pciBusIdle,
    // clock-run open-drain pin
    input  wire logic                      clkrunIn,
    output logic                           clkrunOut,
    output logic                           clkrunOeN,
    output logic                           pciClkOn,
    // configuration cycles
    output hbs_pkg::hbs_cfg_cycle_type     cfgCycle,
    input  wire logic                      cfgRespValid,
    input  wire logic [31:0]               cfgRespData,
    // memory and power
    output logic [NUM_BANKS-1:0]           ckeOut,
    output logic                           sdramTech,
    input  wire logic                      cpuIdle,
    output logic                           coreClkGate,
    // smm memory
    output logic                           extendedSmmMemoryMode,
    output logic [1:0]                     smmSizeSel
);

    hbs_pkg::hbs_state_type s_q;
    hbs_pkg::hbs_state_type s_d;

    logic       allIdle;
    logic [4:0] devSel;
    logic [2:0] pick;
    logic       found;
    int         idx;

    assign allIdle = (&reqN) && (s_q.owner == hbs_pkg::OWNER_NONE)
                     && pciBusIdle;
    assign devSel  = s_q.cfgAddr[15:11];

    // round-robin search starting after the last owner
    always_comb begin
        pick  = '0;
        found = 1'b0;
        idx   = 0;
        for (int i = 1; i <= NUM_MASTERS; i++) begin
            idx = (int'(s_q.lastOwner) + i) % NUM_MASTERS;
            if (!found && !reqN[idx]) begin
                found = 1'b1;
                pick  = 3'(idx);
            end
        end
    end

    // next-state logic for the whole block
    always_comb begin
        s_d           = s_q;
        s_d.rdData    = '0;
        s_d.cfg.valid = 1'b0;

        // strap capture on the first edge after reset release
        if (!s_q.strapDone) begin                                     // RQ1
            s_d.strapDone = 1'b1;                                     // RQ20
            s_d.boot.host100 = (strapPins.hostFreq != hbs_pkg::STRAP_OPEN)
                && (strapPins.moduleConfig != hbs_pkg::STRAP_OPEN); // RQ2 RQ15
            s_d.boot.ioqDepth =
                (strapPins.queueDepth == hbs_pkg::STRAP_OPEN) ?
                hbs_pkg::IOQ_DEPTH_MAX : hbs_pkg::IOQ_DEPTH_MIN;      // RQ3
            s_d.boot.quickStartMode = strapPins.quickStart;          // RQ4
            s_d.boot.agpEnable =
                (strapPins.agpDisable == hbs_pkg::STRAP_OPEN);        // RQ5
            s_d.boot.extModule = strapPins.moduleConfig;             // RQ6
            s_d.boot.mobileBuffers = strapPins.hostBufferMode;       // RQ7
        end

        // register writes
        if (regWr) begin
            unique case (regAddr)
                hbs_pkg::OFS_CFG_ADDR: s_d.cfgAddr = regWdata;
                hbs_pkg::OFS_PM_CTRL:  s_d.pmCtrl  = regWdata[2:0];
                hbs_pkg::OFS_MEM_CTRL: begin
                    s_d.bankEn    = regWdata[NUM_BANKS-1:0];          // RQ14
                    s_d.sdramTech = regWdata[hbs_pkg::MEM_TECH_BIT];  // RQ16
                end
                hbs_pkg::OFS_SMM_CTRL: begin
                    s_d.smmExt  = regWdata[hbs_pkg::SMM_EXT_BIT];     // RQ18
                    s_d.smmSize = regWdata[hbs_pkg::SMM_SIZE_LSB+:2];
                end
                default: ;
            endcase
        end

        // a data-port access with the enable bit set starts a cycle
        if ((regWr || regRd) && regAddr == hbs_pkg::OFS_CFG_DATA
            && s_q.cfgAddr[hbs_pkg::CFG_EN_BIT]) begin               // RQ10
            s_d.cfg.valid    = 1'b1;
            s_d.cfg.write    = regWr;
            s_d.cfg.data     = regWdata;
            s_d.cfg.internal = 1'b0;
            if (s_q.cfgAddr[23:16] != 8'h00) begin
                // type 1: forwarded beyond the local bus
                s_d.cfg.ad = {8'h00, s_q.cfgAddr[23:2], 2'b01};
            end else begin
                s_d.cfg.ad = {21'h000000, s_q.cfgAddr[10:2], 2'b00};
                if (devSel == 5'h00) begin
                    s_d.cfg.internal = 1'b1;                          // RQ11
                end else if (devSel <= 5'h14) begin
                    // device n selects line 11+n: agp on 12, rest 13 up
                    s_d.cfg.ad[5'd11 + devSel] = 1'b1;               // RQ12
                end
            end
        end
        if (cfgRespValid) begin
            s_d.cfgRdData = cfgRespData;
        end

        // register reads, data stands for one cycle only
        if (regRd) begin
            unique case (regAddr)
                hbs_pkg::OFS_CFG_ADDR: s_d.rdData = s_q.cfgAddr;
                hbs_pkg::OFS_CFG_DATA: s_d.rdData = s_q.cfgRdData;
                hbs_pkg::OFS_PM_CTRL:  s_d.rdData = {29'h0, s_q.pmCtrl};
                hbs_pkg::OFS_MEM_CTRL: s_d.rdData = {23'h0, s_q.sdramTech,
                                                     2'h0, s_q.bankEn};
                hbs_pkg::OFS_SMM_CTRL: s_d.rdData = {29'h0, s_q.smmSize,
                                                     s_q.smmExt};
                hbs_pkg::OFS_STRAPS:   s_d.rdData = {23'h0, s_q.boot};
                hbs_pkg::OFS_STATUS:   s_d.rdData = {17'h0, s_q.pciClkOn,
                    s_q.coreClkGate, s_q.crState, s_q.owner,
                    3'h0, s_q.gntN};
                default:               s_d.rdData = '0;
            endcase
        end

        // arbiter: one idle cycle between grants for bus turnaround
        if (s_q.owner == hbs_pkg::OWNER_NONE) begin
            if (found && s_q.pmCtrl[hbs_pkg::PM_ARB_EN]) begin
                s_d.owner       = pick;                               // RQ8
                s_d.gntN        = '1;
                s_d.gntN[pick]  = 1'b0;
            end
        end else if (reqN[s_q.owner]) begin
            s_d.lastOwner = s_q.owner;
            s_d.owner     = hbs_pkg::OWNER_NONE;
            s_d.gntN      = '1;
        end

        // clock-run: release the line after idle, stop if nobody holds it
        unique case (s_q.crState)
            hbs_pkg::CR_RUN: begin
                if (s_q.pmCtrl[hbs_pkg::PM_CLKRUN_EN] && allIdle) begin
                    s_d.crCnt = s_q.crCnt + 4'h1;
                    if (s_q.crCnt == hbs_pkg::IDLE_CYCLES - 4'h1) begin
                        s_d.crState   = hbs_pkg::CR_RELEASE;
                        s_d.clkrunOeN = 1'b1;
                        s_d.crCnt     = '0;
                    end
                end else begin
                    s_d.crCnt = '0;
                end
            end
            hbs_pkg::CR_RELEASE: begin
                s_d.crCnt = s_q.crCnt + 4'h1;
                if (!clkrunIn || !(&reqN)) begin
                    // a device holds the line low: keep the clock
                    s_d.crState   = hbs_pkg::CR_RUN;                  // RQ9
                    s_d.clkrunOeN = 1'b0;
                    s_d.crCnt     = '0;
                end else if (s_q.crCnt == hbs_pkg::CR_WAIT - 4'h1) begin
                    s_d.crState  = hbs_pkg::CR_STOPPED;
                    s_d.pciClkOn = 1'b0;
                    s_d.crCnt    = '0;
                end
            end
            hbs_pkg::CR_STOPPED: begin
                if (!clkrunIn || !(&reqN)
                    || !s_q.pmCtrl[hbs_pkg::PM_CLKRUN_EN]) begin
                    s_d.crState   = hbs_pkg::CR_RUN;                  // RQ9
                    s_d.clkrunOeN = 1'b0;
                    s_d.pciClkOn  = 1'b1;
                end
            end
            default: begin
                s_d.crState   = hbs_pkg::CR_RUN;
                s_d.clkrunOeN = 1'b0;
                s_d.pciClkOn  = 1'b1;
            end
        endcase

        // core clock gate needs both processor and pci quiet
        s_d.coreClkGate = s_q.pmCtrl[hbs_pkg::PM_GCLK_EN] && cpuIdle
                          && allIdle;                                 // RQ17
    end

    // single state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= hbs_pkg::STATE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs taken straight from the state register, except clkrunOut tied low
    assign regRdata   = s_q.rdData;
    assign bootCfg    = s_q.boot;   // agp block runs on its own clock RQ19
    assign gntN       = s_q.gntN;
    assign clkrunOut  = 1'b0;       // open drain: only ever pulls low
    assign clkrunOeN  = s_q.clkrunOeN;
    assign pciClkOn   = s_q.pciClkOn;
    assign cfgCycle   = s_q.cfg;
    // no eight-bank or second-address-bus support: six enables only
    assign ckeOut     = s_q.bankEn;                                   // RQ14
    assign sdramTech  = s_q.sdramTech;
    assign coreClkGate = s_q.coreClkGate;
    assign extendedSmmMemoryMode = s_q.smmExt;
    assign smmSizeSel = s_q.smmSize;

endmodule // hbs_bridge_ctrl

`default_nettype wire

// ### bench/hbs_bridge_props.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of grants, clock-run, straps and config cycles
module hbs_bridge_props #(
    parameter int NUM_MASTERS = hbs_pkg::NUM_MASTERS,
    parameter int NUM_BANKS   = hbs_pkg::NUM_BANKS
) (
    // clock and reset
    input wire logic                        clk,
    input wire logic                        rst_n,
    // register port
    input wire logic [hbs_pkg::ADDR_W-1:0]  regAddr,
    input wire logic [31:0]                 regWdata,
    input wire logic                        regWr,
    input wire logic                        regRd,
    // device pins
    input wire hbs_pkg::hbs_boot_type       bootCfg,
    input wire logic [NUM_MASTERS-1:0]      reqN,
    input wire logic [NUM_MASTERS-1:0]      gntN,
    input wire logic                        clkrunIn,
    input wire logic                        clkrunOeN,
    input wire logic                        pciClkOn,
    input wire hbs_pkg::hbs_cfg_cycle_type  cfgCycle,
    input wire logic [NUM_BANKS-1:0]        ckeOut,
    input wire logic                        cpuIdle,
    input wire logic                        coreClkGate
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_ONE_GNT: assert property ($onehot0(~gntN))
        else $error("more than one grant");
    AST_GNT_DROP: assert property (
        |(~gntN & reqN) |=> &gntN) else $error("grant kept after release");
    AST_CKE: assert property (
        regWr && regAddr == hbs_pkg::OFS_MEM_CTRL
        |=> ckeOut == $past(regWdata[NUM_BANKS-1:0]))
        else $error("bank clock enables not taken");
    AST_CFG_SRC: assert property (
        cfgCycle.valid |-> $past(regWr || regRd)
        && $past(regAddr) == hbs_pkg::OFS_CFG_DATA)
        else $error("config cycle without data access");
    AST_CFG_AD11: assert property (
        cfgCycle.valid && cfgCycle.ad[1:0] == 2'b00 |-> !cfgCycle.ad[11])
        else $error("line 11 used as select");
    // the first edge after release still sees reset values, the second sees the captured straps
    AST_BOOT_HOLD: assert property (
        $past(rst_n) && $past(rst_n, 2) |-> $stable(bootCfg))
        else $error("boot configuration moved");
    AST_CR_STOP: assert property (
        $fell(pciClkOn) |-> clkrunOeN && $past(clkrunOeN) && $past(clkrunIn))
        else $error("clock stopped without release");
    AST_CR_WAKE: assert property (
        clkrunOeN && !clkrunIn |=> !clkrunOeN && pciClkOn)
        else $error("clock-run request ignored");
    AST_GATE: assert property (
        coreClkGate |-> $past(cpuIdle) && $past(&reqN))
        else $error("core clock gated while busy");
endmodule // hbs_bridge_props
bind hbs_bridge_ctrl hbs_bridge_props #(
    .NUM_MASTERS(NUM_MASTERS),
    .NUM_BANKS(NUM_BANKS)
) hbs_bridge_props_inst (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
    .bootCfg, .reqN, .gntN, .clkrunIn, .clkrunOeN, .pciClkOn, .cfgCycle,
    .ckeOut, .cpuIdle, .coreClkGate);
`default_nettype wire

// ### bench/hbs_pci_far.sv
`timescale 1ns/1ps
`default_nettype none
// pci masters and targets on the far side of the bridge
module hbs_pci_far (
    // clock and reset
    input wire logic                       clk,
    input wire logic                       rst_n,
    // bench control and bridge outputs
    input wire logic [4:0]                 want,
    input wire logic [4:0]                 gntN,
    input wire logic                       clkrunOeN,
    input wire hbs_pkg::hbs_cfg_cycle_type cfgCycle,
    // lines back to the bridge
    output logic [4:0]                     reqN,
    output logic                           pciBusIdle,
    output logic                           clkrunIn,
    output logic                           cfgRespValid,
    output logic [31:0]                    cfgRespData
);
    // each master holds its own request line while it wants the bus
    assign reqN = ~want;
    assign pciBusIdle = &gntN;
    // pulled-up wire: low if the bridge or any waiting master pulls it
    assign clkrunIn = clkrunOeN & ~(|want);
    // south bridge expected on select line 18, any line 12 up answers
    // external targets answer reads on line 12 and up, never device 0;
    // data lines flip while idle so stale data never looks valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgRespValid <= 1'b0;
            cfgRespData <= 32'h0;
        end else begin
            cfgRespValid <= cfgCycle.valid & ~cfgCycle.write
                & |cfgCycle.ad[31:12];
            cfgRespData <= cfgCycle.valid ? ~cfgCycle.ad : ~cfgRespData;
        end
    end
endmodule // hbs_pci_far
`default_nettype wire

// ### bench/tb_hbs_bridge_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_hbs_bridge_ctrl;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic cpuIdle = 1'b0;
    logic [4:0] want = 5'h0;
    hbs_pkg::hbs_strap_type strapPins = 6'h09;
    logic [31:0] regRdata, cfgRespData, d;
    hbs_pkg::hbs_boot_type bootCfg;
    hbs_pkg::hbs_cfg_cycle_type cfgCycle;
    logic [4:0] reqN, gntN;
    logic [5:0] ckeOut;
    logic [1:0] smmSizeSel;
    logic pciBusIdle, clkrunIn, clkrunOeN, pciClkOn, cfgRespValid;
    logic sdramTech, coreClkGate, extendedSmmMemoryMode;
    int failures = 0;
    int checked = 0;
    int n, cyc;

    hbs_bridge_ctrl hbs_bridge_ctrl_inst (.clk, .rst_n, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .strapPins, .bootCfg, .reqN, .gntN,
        .pciBusIdle, .clkrunIn, .clkrunOut(), .clkrunOeN, .pciClkOn,
        .cfgCycle, .cfgRespValid, .cfgRespData, .ckeOut, .sdramTech,
        .cpuIdle, .coreClkGate, .extendedSmmMemoryMode, .smmSizeSel);
    hbs_pci_far hbs_pci_far_inst (.clk, .rst_n, .want, .gntN, .clkrunOeN,
        .cfgCycle, .reqN, .pciBusIdle, .clkrunIn, .cfgRespValid,
        .cfgRespData);

    // 125 MHz clock and a hang guard well past the expected run
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] v);
        checked++;
        if (v !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", s, e, v);
        end
    endtask
    // one-cycle strobes; a free cycle between calls keeps drivers apart
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge clk);
        regAddr <= a;
        regWdata <= w;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk("read data", e, regRdata);
    endtask
    task automatic reset_with(input hbs_pkg::hbs_strap_type s);
        @(posedge clk);
        rst_n <= 1'b0;
        strapPins <= s;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
    endtask
    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        reset_with(6'h09);
        // module defaults: 66 MHz, depth 8, quick start, agp on, mobile
        chk("boot", 32'h08d, 32'(bootCfg));
        strapPins <= 6'h34;
        rdchk(hbs_pkg::OFS_STRAPS, 32'h08d);
        rdchk(hbs_pkg::OFS_PM_CTRL, 32'h4);
        rdchk(hbs_pkg::OFS_SMM_CTRL, 32'h0);
        rdchk(8'h1c, 32'h0);
        wr(hbs_pkg::OFS_MEM_CTRL, 32'h13f);
        chk("cke", 32'h3f, 32'(ckeOut));
        chk("sdram", 32'h1, 32'(sdramTech));
        rdchk(hbs_pkg::OFS_MEM_CTRL, 32'h13f);
        wr(hbs_pkg::OFS_MEM_CTRL, 32'h02a);
        chk("cke edo", 32'h2a, 32'({sdramTech, ckeOut}));
        wr(hbs_pkg::OFS_SMM_CTRL, 32'h7);
        chk("smm", 32'h7, 32'({smmSizeSel, extendedSmmMemoryMode}));
        // device 0 is internal, 1 is agp on line 12, others higher
        foreach (ckeOut[i]) begin
            wr(hbs_pkg::OFS_CFG_ADDR, 32'h80000000 | (i << 11));
            wr(hbs_pkg::OFS_CFG_DATA, 32'hc0de0000 + i);
            d = (i == 0) ? 32'h0 : 32'h1 << (11 + i);
            chk("cfg ad", d, cfgCycle.ad);
            chk("cfg int", 32'(i == 0), 32'(cfgCycle.internal));
            chk("cfg data", 32'hc0de0000 + i, cfgCycle.data);
        end
        wr(hbs_pkg::OFS_CFG_ADDR, 32'h00001000);
        wr(hbs_pkg::OFS_CFG_DATA, 32'h1);
        chk("cfg off", 32'h0, 32'(cfgCycle.valid));
        wr(hbs_pkg::OFS_CFG_ADDR, 32'h80000800);
        rdchk(hbs_pkg::OFS_CFG_DATA, 32'h0);
        repeat (2) @(posedge clk);
        rdchk(hbs_pkg::OFS_CFG_DATA, 32'hffffefff);
        // round robin: master 0 first, then 2 after a free cycle
        @(posedge clk) want <= 5'h05;
        #1;
        for (n = 0; n < 10 && gntN === 5'h1f; n++) #8;
        chk("gnt0", 32'h1e, 32'(gntN));
        @(posedge clk) want <= 5'h04;
        #1;
        for (n = 0; n < 10 && gntN !== 5'h1b; n++) #8;
        chk("gnt2", 32'h1b, 32'(gntN));
        @(posedge clk) want <= 5'h0;
        wr(hbs_pkg::OFS_PM_CTRL, 32'h0);
        @(posedge clk) want <= 5'h08;
        repeat (10) @(posedge clk);
        #1;
        chk("arb off", 32'h1f, 32'(gntN));
        @(posedge clk) want <= 5'h0;
        // idle bus lets the clock stop; a waiting master restarts it
        wr(hbs_pkg::OFS_PM_CTRL, 32'h6);
        for (n = 0; n < 20 && clkrunOeN !== 1'b1; n++) #8;
        chk("cr release", 32'h1, 32'(clkrunOeN));
        for (n = 0; n < 10 && pciClkOn !== 1'b0; n++) #8;
        chk("clk stop", 32'h0, 32'(pciClkOn));
        rdchk(hbs_pkg::OFS_STATUS, 32'h171f);
        @(posedge clk) want <= 5'h10;
        #1;
        for (n = 0; n < 4 && pciClkOn !== 1'b1; n++) #8;
        chk("clk run", 32'h1, 32'(pciClkOn));
        for (n = 0; n < 10 && gntN !== 5'h0f; n++) #8;
        chk("gnt4", 32'h0f, 32'(gntN));
        @(posedge clk) want <= 5'h0;
        wr(hbs_pkg::OFS_PM_CTRL, 32'h1);
        @(posedge clk) cpuIdle <= 1'b1;
        #1;
        for (n = 0; n < 10 && coreClkGate !== 1'b1; n++) #8;
        chk("gate", 32'h1, 32'(coreClkGate));
        @(posedge clk) cpuIdle <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("ungate", 32'h0, 32'(coreClkGate));
        // strapped: agp off, depth 1, and no 100 MHz in standard mode
        reset_with(6'h34);
        chk("boot2", 32'h010, 32'(bootCfg));
        rdchk(hbs_pkg::OFS_STRAPS, 32'h010);
        conclude();
    end
endmodule // tb_hbs_bridge_ctrl
`default_nettype wire
